/* File: cpm_composer.sv */
// composing end: forwards headers and data, inserts end sequences
// assumes APB master on pclk; link joined to a vsm_demux
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "cpm_regs.svh"

module vsm_composer (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       ce,
   input  wire logic [11:0]                paddr,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [31:0]                pwdata,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   output logic                            irq,
   input  wire logic                       up_valid,
   output logic                            up_ready,
   input  wire logic [7:0]                 up_data,
   input  wire logic                       up_hdr,
   input  wire vsm_pkg::hdr_kind_type      up_kind,
   input  wire vsm_pkg::stream_index_type  up_index,
   input  wire logic                       up_intra,
   input  wire logic [1:0]                 up_fid,
   input  wire logic                       up_ext,
   output logic                            bc_valid,
   output logic                            bc_mux,
   output vsm_pkg::stream_index_type       bc_index,
   vsm_link_if.enc                         lnk
);
   import vsm_pkg::*;

   typedef enum {st_pass, st_z0, st_z1, st_tail, st_idx} state_type;

   state_type        st_q;
   state_type        st_d;
   logic             pend_q;
   logic             pend_d;
   stream_index_type pidx_q;
   logic             ctrl_q;
   logic [2:0]       mask_q;
   logic [2:0]       sts_q;
   logic [2:0]       sts_d;
   logic [2:0]       ev;
   logic [3:0]       pic_sent_q;
   logic [3:0]       need_intra_q;
   logic             acc;
   logic             wr;
   logic             cmd;
   logic             cmd_ok;
   logic             fwd;
   logic             fwd_pic;

   // ---------------------------------------------------------------
   // APB slave, one wait state
   // ---------------------------------------------------------------
   assign acc    = ce & psel & penable & pready;
   assign wr     = acc & pwrite;
   assign cmd    = wr & (paddr == `REG_CMD) & pwdata[`CMD_GO];
   assign cmd_ok = cmd & ctrl_q & pic_sent_q[pwdata[1:0]] & ~pend_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= psel & penable & ~pready;
         if (psel & penable & ~pready) begin
            pslverr <= 1'b0;
            case (paddr)
               `REG_CTRL: prdata <= {31'h0, ctrl_q};
               `REG_CMD:  prdata <= '0;
               `REG_STAT: prdata <= {23'h0, pend_q, need_intra_q, pic_sent_q};
               `REG_IRQ:  prdata <= {29'h0, sts_q};
               `REG_MASK: prdata <= {29'h0, mask_q};
               default: begin
                  prdata  <= '0;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `CTRL_RESET;
         mask_q <= `MASK_RESET;
      end else if (wr) begin
         if (paddr == `REG_CTRL) begin
            ctrl_q <= pwdata[`CTRL_END_EN];
         end
         if (paddr == `REG_MASK) begin
            mask_q <= pwdata[2:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt status: read clears what was returned, set wins
   // ---------------------------------------------------------------
   assign ev[`IRQ_END_SENT] = ce & (st_q == st_idx);
   assign ev[`IRQ_REFUSED]  = cmd & ~cmd_ok;
   assign ev[`IRQ_INTER]    = fwd_pic & need_intra_q[up_index] & ~up_intra;

   always_comb begin
      sts_d = sts_q;
      if (acc && !pwrite && paddr == `REG_IRQ) begin
         sts_d = sts_q & ~prdata[2:0];
      end
      sts_d = sts_d | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_q <= '0;
         irq   <= 1'b0;
      end else if (ce) begin
         sts_q <= sts_d;
         irq   <= |(sts_d & mask_q);
      end
   end

   // ---------------------------------------------------------------
   // end sequence sequencer
   // ---------------------------------------------------------------
   assign fwd     = ce & up_valid & up_ready & (st_q == st_pass);
   assign fwd_pic = fwd & up_hdr & (up_kind == hdr_picture);

   always_comb begin
      st_d   = st_q;
      pend_d = pend_q | cmd_ok;
      case (st_q)
         st_pass: if (pend_q) st_d = st_z0;
         st_z0:   st_d = st_z1;
         st_z1:   st_d = st_tail;
         st_tail: st_d = st_idx;
         st_idx: begin
            st_d   = st_pass;
            pend_d = 1'b0;
         end
         default: st_d = st_pass;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q     <= st_pass;
         pend_q   <= 1'b0;
         pidx_q   <= '0;
         up_ready <= 1'b0;
      end else if (ce) begin
         st_q     <= st_d;
         pend_q   <= pend_d;
         up_ready <= (st_d == st_pass) & ~pend_d;
         if (cmd_ok) begin
            pidx_q <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pic_sent_q   <= '0;
         need_intra_q <= '0;
      end else if (ce) begin
         for (int i = 0; i < `STREAM_COUNT; i++) begin
            if (fwd_pic && up_index == i[1:0]) begin
               pic_sent_q[i]   <= 1'b1;
               need_intra_q[i] <= 1'b0;
            end else if (st_q == st_idx && pidx_q == i[1:0]) begin
               pic_sent_q[i]   <= 1'b0;
               need_intra_q[i] <= 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // link drive
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lnk.valid <= 1'b0;
         lnk.data  <= '0;
         lnk.hdr   <= 1'b0;
         lnk.kind  <= hdr_picture;
         lnk.index <= '0;
         lnk.mux   <= 1'b0;
         lnk.intra <= 1'b0;
         lnk.fid   <= '0;
         lnk.ext   <= 1'b0;
      end else if (ce) begin
         lnk.valid <= fwd | (st_q != st_pass);
         lnk.hdr   <= fwd & up_hdr;
         lnk.mux   <= `MUX_FLAG_ON;
         case (st_q)
            st_pass: begin
               lnk.data  <= up_data;
               lnk.kind  <= up_kind;
               lnk.index <= up_index;
               lnk.intra <= up_intra;
               lnk.fid   <= up_fid;
               lnk.ext   <= up_ext;
            end
            st_z0:   lnk.data <= `END_ZERO_BYTE;
            st_z1:   lnk.data <= `END_ZERO_BYTE;
            st_tail: lnk.data <= {`END_TAIL_BITS, pidx_q[1]};
            st_idx:  lnk.data <= {pidx_q[0], 7'h00};
            default: lnk.data <= `END_ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bc_valid <= 1'b0;
         bc_mux   <= 1'b0;
         bc_index <= '0;
      end else if (ce) begin
         bc_valid <= lnk.bc_valid & lnk.bc_mux;
         bc_mux   <= lnk.bc_mux;
         bc_index <= lnk.bc_index;
      end
   end
endmodule : vsm_composer
`default_nettype wire

/* File: cpm_regs.svh */
// constants for the multiplexed sub-stream link and the composer registers
// assumes inclusion by bare name from the design files
`ifndef VSM_REGS_SVH
`define VSM_REGS_SVH

`define STREAM_COUNT  4
`define MUX_FLAG_ON   1'b1
`define END_ZERO_BYTE 8'h00
`define END_TAIL_BITS 7'h7c

`define REG_CTRL      12'h000
`define REG_CMD       12'h004
`define REG_STAT      12'h008
`define REG_IRQ       12'h00c
`define REG_MASK      12'h010

`define CTRL_END_EN   0
`define CMD_GO        4
`define STAT_BUSY     8
`define IRQ_END_SENT  0
`define IRQ_REFUSED   1
`define IRQ_INTER     2

`define CTRL_RESET    1'b0
`define MASK_RESET    3'h0

`endif

/* File: cpm_pkg.sv */
// types shared by the link interface and both ends
// assumes nothing beyond a SystemVerilog compiler
package vsm_pkg;
   typedef enum logic [1:0] {
      hdr_picture,
      hdr_group,
      hdr_slice,
      hdr_end_of_stream
   } hdr_kind_type;
   typedef logic [1:0] stream_index_type;
endpackage : vsm_pkg

/* File: cpm_link_if.sv */
// link between the composing encoder end and the receiving demux end
// assumes both ends run on the same clock; one byte per valid cycle
`timescale 1ns/10ps
`default_nettype none
interface vsm_link_if;
   import vsm_pkg::*;
   logic             valid;
   logic [7:0]       data;
   logic             hdr;
   hdr_kind_type     kind;
   stream_index_type index;
   logic             mux;
   logic             intra;
   logic [1:0]       fid;
   logic             ext;
   logic             bc_valid;
   logic             bc_mux;
   stream_index_type bc_index;

   modport enc (output valid, data, hdr, kind, index, mux, intra, fid, ext,
                input  bc_valid, bc_mux, bc_index);
   modport dec (input  valid, data, hdr, kind, index, mux, intra, fid, ext,
                output bc_valid, bc_mux, bc_index);
endinterface : vsm_link_if
`default_nettype wire

/* File: cpm_demux.sv */
// receiving end: routes the composed stream to its sub-streams
// assumes the link is driven on pclk by the composer end
`timescale 1ns/10ps
`default_nettype none
`include "cpm_regs.svh"

module vsm_demux (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       ce,
   vsm_link_if.dec                         lnk,
   output logic                            out_valid,
   output logic [7:0]                      out_data,
   output logic                            out_hdr,
   output vsm_pkg::stream_index_type       out_index,
   output logic [1:0]                      cur_fid,
   output logic                            cur_ext,
   output logic [3:0]                      active,
   output logic                            end_pulse,
   output vsm_pkg::stream_index_type       end_index,
   output logic                            fwd_err,
   output logic                            mux_err,
   input  wire logic                       freeze_req,
   input  wire logic                       update_req,
   output logic [3:0]                      freeze_out,
   output logic [3:0]                      update_out,
   input  wire logic [3:0]                 res_req,
   output logic [3:0]                      res_grant,
   input  wire logic                       bc_req,
   input  wire vsm_pkg::stream_index_type  bc_sel
);
   import vsm_pkg::*;

   logic             take;
   logic             is_hdr;
   logic             pic;
   logic             grp;
   logic             all_end;
   logic             tail;
   logic             end_hit;
   stream_index_type end_idx;
   stream_index_type rt;
   stream_index_type cur_q;
   logic             z1_q;
   logic             z2_q;
   logic             pend_q;
   logic             pend_hi_q;
   logic [3:0]       restart_q;
   logic [1:0]       fid_q [`STREAM_COUNT];
   logic             ext_q [`STREAM_COUNT];

   // ---------------------------------------------------------------
   // decode of the incoming byte
   // ---------------------------------------------------------------
   assign take    = ce & lnk.valid;
   assign is_hdr  = take & lnk.hdr & (lnk.kind != hdr_end_of_stream);
   assign pic     = take & lnk.hdr & (lnk.kind == hdr_picture);
   assign grp     = take & lnk.hdr & (lnk.kind == hdr_group);
   assign all_end = take & lnk.hdr & (lnk.kind == hdr_end_of_stream);
   // any order of indices is taken as it comes
   assign rt      = is_hdr ? lnk.index : cur_q;

   // aligned zero bytes then 1111100 open the end sequence
   assign tail    = take & ~lnk.hdr & z1_q & z2_q & ~pend_q
                    & (lnk.data[7:1] == `END_TAIL_BITS);
   assign end_hit = take & pend_q;
   assign end_idx = {pend_hi_q, lnk.data[7]};

   // ---------------------------------------------------------------
   // current sub-stream
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_q <= '0;
      end else if (is_hdr) begin
         cur_q <= lnk.index;
      end
   end

   // ---------------------------------------------------------------
   // end sequence detector
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         z1_q      <= 1'b0;
         z2_q      <= 1'b0;
         pend_q    <= 1'b0;
         pend_hi_q <= 1'b0;
      end else if (take) begin
         z1_q      <= ~lnk.hdr & (lnk.data == `END_ZERO_BYTE);
         z2_q      <= z1_q & ~lnk.hdr;
         pend_q    <= tail;
         pend_hi_q <= lnk.data[0];
      end
   end

   // ---------------------------------------------------------------
   // per-stream activity and restart tracking
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active    <= '0;
         restart_q <= '0;
      end else if (ce) begin
         for (int i = 0; i < `STREAM_COUNT; i++) begin
            if (pic && lnk.index == i[1:0]) begin
               active[i]    <= 1'b1;
               restart_q[i] <= 1'b0;
            end else if (end_hit && end_idx == i[1:0]) begin
               active[i]    <= 1'b0;
               restart_q[i] <= 1'b1;
            end else if (all_end) begin
               active[i]    <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // separate decoding state per sub-stream
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < `STREAM_COUNT; i++) begin
            fid_q[i] <= '0;
            ext_q[i] <= 1'b0;
         end
      end else if (ce) begin
         for (int i = 0; i < `STREAM_COUNT; i++) begin
            if ((pic || grp) && lnk.index == i[1:0]) begin
               fid_q[i] <= lnk.fid;
            end
            if (pic && lnk.index == i[1:0]) begin
               ext_q[i] <= lnk.ext;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // routed output
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid <= 1'b0;
         out_data  <= '0;
         out_hdr   <= 1'b0;
         out_index <= '0;
         cur_fid   <= '0;
         cur_ext   <= 1'b0;
      end else if (ce) begin
         out_valid <= take;
         if (take) begin
            out_data  <= lnk.data;
            out_hdr   <= lnk.hdr;
            out_index <= rt;
            cur_fid   <= (pic || grp) ? lnk.fid : fid_q[rt];
            cur_ext   <= pic ? lnk.ext : ext_q[rt];
         end
      end
   end

   // ---------------------------------------------------------------
   // events
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         end_pulse <= 1'b0;
         end_index <= '0;
         fwd_err   <= 1'b0;
         mux_err   <= 1'b0;
      end else if (ce) begin
         end_pulse <= end_hit;
         if (end_hit) begin
            end_index <= end_idx;
         end
         fwd_err   <= pic & restart_q[lnk.index] & ~lnk.intra;
         mux_err   <= is_hdr & (lnk.mux != `MUX_FLAG_ON);
      end
   end

   // ---------------------------------------------------------------
   // general requests, priority and back-channel
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freeze_out   <= '0;
         update_out   <= '0;
         res_grant    <= '0;
         lnk.bc_valid <= 1'b0;
         lnk.bc_mux   <= 1'b0;
         lnk.bc_index <= '0;
      end else if (ce) begin
         freeze_out   <= {4{freeze_req}} & active;
         update_out   <= {4{update_req}} & active;
         // isolate lowest requesting index
         res_grant    <= res_req & 4'(~res_req + 4'h1);
         lnk.bc_valid <= bc_req;
         lnk.bc_mux   <= `MUX_FLAG_ON;
         lnk.bc_index <= bc_sel;
      end
   end
endmodule : vsm_demux
`default_nettype wire

/* File: cpm_link_checker.sv */
// checker on the link between the composer and demux ends
// assumes link signals change on pclk, presetn active low
`timescale 1ns/10ps
`default_nettype none
module vsm_link_checker (
   input wire logic                   pclk,
   input wire logic                   presetn,
   input wire logic                   valid,
   input wire logic [7:0]             data,
   input wire logic                   hdr,
   input wire vsm_pkg::hdr_kind_type  kind,
   input wire vsm_pkg::stream_index_type index,
   input wire logic                   mux,
   input wire logic                   bc_valid,
   input wire logic                   bc_mux
);
   import vsm_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // end sequence tracking
   // ----------------------------------------
   logic       z1_q, z2_q, t3_q, b0_q;
   logic [3:0] pic_q;
   logic       zb;
   assign zb = valid && !hdr && data == 8'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         z1_q <= 1'b0;
         z2_q <= 1'b0;
         t3_q <= 1'b0;
         b0_q <= 1'b0;
      end else begin
         z1_q <= zb;
         z2_q <= z1_q && zb;
         t3_q <= z2_q && valid && data[7:1] == 7'h7c;
         b0_q <= data[0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pic_q <= 4'h0;
      end else if (valid && hdr && kind == hdr_picture) begin
         pic_q[index] <= 1'b1;
      end else if (t3_q && valid) begin
         pic_q[{b0_q, data[7]}] <= 1'b0;
      end
   end
   sequence s_zero_pair;
      zb ##1 zb;
   endsequence
   sequence s_end_head;
      s_zero_pair ##1 valid;
   endsequence
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_mux_flag_set: assert property (valid && hdr |-> mux)
      else $error("header without multiplex flag");
   a_bc_mux_set: assert property (bc_valid |-> bc_mux)
      else $error("back-channel without multiplex flag");
   a_hdr_with_byte: assert property (hdr |-> valid)
      else $error("header marker without byte");
   a_end_zero_run: assert property (s_zero_pair |=> valid)
      else $error("gap inside end code");
   a_end_code_prefix: assert property (s_end_head |-> !hdr && data[7:1] == 7'h7c)
      else $error("end code third byte wrong");
   a_end_index_tail: assert property (s_end_head |=> valid && !hdr && data[6:0] == 7'h00)
      else $error("end code tail byte wrong");
   a_end_prefix_lead: assert property (valid && !hdr && data[7:1] == 7'h7c |-> z2_q)
      else $error("end code not byte aligned");
   a_end_after_pic: assert property (t3_q && valid |-> pic_q[{b0_q, data[7]}])
      else $error("end code before any picture");
endmodule : vsm_link_checker
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench joining composer and demux over the link
// assumes the design files and cpm_regs.svh are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "cpm_regs.svh"
module tb_top;
   import vsm_pkg::*;
   logic             pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
   logic             psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]      paddr = 12'h000;
   logic [31:0]      pwdata = 32'h0000_0000, prdata, rdv;
   logic             pready, pslverr, irq, up_ready, bc_valid, bc_mux, err_v;
   logic             up_valid = 1'b0, up_hdr = 1'b0, up_intra = 1'b0, up_ext = 1'b0;
   logic [7:0]       up_data = 8'h00, out_data, lg_data;
   hdr_kind_type     up_kind = hdr_picture;
   stream_index_type up_index = 2'h0, bc_sel = 2'h0, bc_index, out_index, end_index, lg_idx;
   logic [1:0]       up_fid = 2'h0, cur_fid, lg_fid;
   logic             out_valid, out_hdr, cur_ext, end_pulse, fwd_err, mux_err, lg_ext, lg_hdr;
   logic [3:0]       active, freeze_out, update_out, res_grant, res_req = 4'h0;
   logic             freeze_req = 1'b0, update_req = 1'b0, bc_req = 1'b0;
   int               error_cnt = 0, total_checks = 0, cyc = 0, end_cnt = 0, fwd_cnt = 0;
   int               mux_cnt = 0;
   vsm_link_if lnk_bus ();
   vsm_composer vsm_composer_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .up_valid(up_valid), .up_ready(up_ready),
      .up_data(up_data), .up_hdr(up_hdr), .up_kind(up_kind), .up_index(up_index),
      .up_intra(up_intra), .up_fid(up_fid), .up_ext(up_ext), .bc_valid(bc_valid),
      .bc_mux(bc_mux), .bc_index(bc_index), .lnk(lnk_bus));
   vsm_demux vsm_demux_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .lnk(lnk_bus),
      .out_valid(out_valid), .out_data(out_data), .out_hdr(out_hdr), .out_index(out_index),
      .cur_fid(cur_fid), .cur_ext(cur_ext), .active(active), .end_pulse(end_pulse),
      .end_index(end_index), .fwd_err(fwd_err), .mux_err(mux_err), .freeze_req(freeze_req),
      .update_req(update_req), .freeze_out(freeze_out), .update_out(update_out),
      .res_req(res_req), .res_grant(res_grant), .bc_req(bc_req), .bc_sel(bc_sel));
   vsm_link_checker vsm_link_checker_inst (.pclk(pclk), .presetn(presetn),
      .valid(lnk_bus.valid), .data(lnk_bus.data), .hdr(lnk_bus.hdr), .kind(lnk_bus.kind),
      .index(lnk_bus.index), .mux(lnk_bus.mux), .bc_valid(lnk_bus.bc_valid),
      .bc_mux(lnk_bus.bc_mux));
   // ----------------------------------------
   // clock, logger, timeout, shared tasks
   // ----------------------------------------
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      if (out_valid === 1'b1) begin
         lg_data <= out_data;
         lg_hdr <= out_hdr;
         lg_idx <= out_index;
         lg_fid <= cur_fid;
         lg_ext <= cur_ext;
      end
      if (end_pulse === 1'b1) end_cnt <= end_cnt + 1;
      if (fwd_err === 1'b1) fwd_cnt <= fwd_cnt + 1;
      if (mux_err === 1'b1) mux_cnt <= mux_cnt + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt = error_cnt + 1;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= wr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdv = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdv, exp);
   endtask : rdc
   task send(input logic h, input hdr_kind_type k, input stream_index_type i, input logic in,
             input logic [1:0] f, input logic e, input logic [7:0] d);
      @(posedge pclk);
      up_valid <= 1'b1;
      up_hdr <= h;
      up_kind <= k;
      up_index <= i;
      up_intra <= in;
      up_fid <= f;
      up_ext <= e;
      up_data <= d;
      do begin
         @(posedge pclk);
      end while (up_ready !== 1'b1);
      up_valid <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask : send
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_route;
      static stream_index_type ord [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
      for (int i = 0; i < 4; i++) begin
         send(1'b1, hdr_picture, ord[i], 1'b1, 2'(i), i[0], 8'h21);
         chk(32'({lg_hdr, lg_data}), 32'h0000_0121);
         send(1'b0, hdr_picture, ~ord[i], 1'b0, 2'h0, 1'b0, 8'(8'h40 + i));
         chk(32'({lg_hdr, lg_data}), 32'(8'h40 + i));
         chk(32'(lg_idx), 32'(ord[i]));
         chk(32'(lg_fid), 32'(i));
      end
      chk(32'(active), 32'h0000_000f);
      send(1'b1, hdr_slice, 2'h0, 1'b0, 2'h2, 1'b0, 8'h21);
      send(1'b0, hdr_picture, 2'h3, 1'b0, 2'h0, 1'b0, 8'h66);
      chk(32'(lg_idx), 32'h0000_0000);
      chk(32'({lg_fid, lg_ext}), 32'h0000_0003);
   endtask : t_route
   task t_refuse;
      apb(1'b1, `REG_CMD, 32'h0000_0013);
      repeat (3) @(posedge pclk);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, `REG_MASK, 32'h0000_0002);
      repeat (3) @(posedge pclk);
      chk(32'(irq), 32'h0000_0001);
      rdc(`REG_IRQ, 32'h0000_0002);
      repeat (3) @(posedge pclk);
      chk(32'(irq), 32'h0000_0000);
   endtask : t_refuse
   task t_end;
      int n;
      int base;
      apb(1'b1, `REG_CTRL, 32'h0000_0001);
      apb(1'b1, `REG_MASK, 32'h0000_0001);
      base = end_cnt;
      apb(1'b1, `REG_CMD, 32'h0000_0012);
      for (n = 0; n < 40 && end_cnt == base; n++) @(posedge pclk);
      chk(32'(end_cnt - base), 32'h0000_0001);
      chk(32'(end_index), 32'h0000_0002);
      repeat (3) @(posedge pclk);
      chk(32'(active), 32'h0000_000b);
      chk(32'(irq), 32'h0000_0001);
      rdc(`REG_IRQ, 32'h0000_0001);
      rdc(`REG_STAT, 32'h0000_004b);
      freeze_req <= 1'b1;
      update_req <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(32'({freeze_out, update_out}), 32'h0000_00bb);
      freeze_req <= 1'b0;
      update_req <= 1'b0;
      apb(1'b1, `REG_CMD, 32'h0000_0012);
      repeat (3) @(posedge pclk);
      rdc(`REG_IRQ, 32'h0000_0002);
      base = fwd_cnt;
      send(1'b1, hdr_picture, 2'h2, 1'b0, 2'h0, 1'b0, 8'h21);
      chk(32'(fwd_cnt - base), 32'h0000_0001);
      rdc(`REG_IRQ, 32'h0000_0004);
      chk(32'(active), 32'h0000_000f);
      send(1'b1, hdr_end_of_stream, 2'h0, 1'b0, 2'h0, 1'b0, 8'h21);
      chk(32'(active), 32'h0000_0000);
   endtask : t_end
   task t_prio_bc;
      static logic [3:0] rq [4] = '{4'hc, 4'ha, 4'hf, 4'h8};
      static logic [3:0] gr [4] = '{4'h4, 4'h2, 4'h1, 4'h8};
      int n;
      for (int i = 0; i < 4; i++) begin
         res_req <= rq[i];
         repeat (2) @(posedge pclk);
         chk(32'(res_grant), 32'(gr[i]));
      end
      ce <= 1'b0;
      res_req <= 4'h1;
      repeat (2) @(posedge pclk);
      chk(32'(res_grant), 32'h0000_0008);
      ce <= 1'b1;
      bc_sel <= 2'h3;
      bc_req <= 1'b1;
      @(posedge pclk);
      bc_req <= 1'b0;
      for (n = 0; n < 10 && bc_valid !== 1'b1; n++) @(posedge pclk);
      chk(32'({bc_valid, bc_mux, bc_index}), 32'h0000_000f);
   endtask : t_prio_bc
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(32'(active), 32'h0000_0000);
      rdc(`REG_CTRL, 32'h0000_0000);
      rdc(`REG_MASK, 32'h0000_0000);
      rdc(12'h020, 32'h0000_0000);
      chk(32'(err_v), 32'h0000_0001);
      t_route;
      t_refuse;
      t_end;
      t_prio_bc;
      chk(32'(mux_cnt), 32'h0000_0000);
      close_out;
   end
endmodule : tb_top
`default_nettype wire
